/* File: hdl/status_reporting_pkg.sv */
// shared constants and carriers for the status reporting block
package status_reporting_pkg;

  // operation status bit positions
  localparam int OPER_TRIG_WAIT_BIT = 0;
  localparam int OPER_ARM_WAIT_BIT  = 1;
  localparam int OPER_SCAN_BIT      = 4;
  localparam logic [15:0] OPER_IMPL_MASK = 16'h0013;

  // standard event bit positions
  localparam int STD_POWER_ON_BIT  = 0;
  localparam int STD_CMD_ERR_BIT   = 2;
  localparam int STD_EXEC_ERR_BIT  = 3;
  localparam int STD_DEV_ERR_BIT   = 4;
  localparam int STD_QUERY_ERR_BIT = 5;
  localparam int STD_OP_DONE_BIT   = 7;
  localparam logic [7:0] STD_IMPL_MASK = 8'hbd;

  // status byte bit positions
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_RQS_BIT = 6;
  localparam int STB_OPR_BIT = 7;

  // values after reset
  localparam logic [15:0] OPER_EVENT_RESET  = 16'h0000;
  localparam logic [15:0] OPER_ENABLE_RESET = 16'h0000;
  localparam logic [7:0]  STD_EVENT_RESET   = 8'h01;
  localparam logic [7:0]  STD_ENABLE_RESET  = 8'h00;
  localparam logic [7:0]  SRQ_ENABLE_RESET  = 8'h00;

  // register selectors on the command port
  typedef enum logic [2:0] {
    SEL_OPER_COND,
    SEL_OPER_EVENT,
    SEL_OPER_ENABLE,
    SEL_STD_EVENT,
    SEL_STD_ENABLE,
    SEL_STATUS_BYTE,
    SEL_SRQ_ENABLE,
    SEL_NONE
  } reg_sel_type;

  // one register access from the command interpreter
  typedef struct packed {
    logic        valid;
    logic        write;
    reg_sel_type sel;
    logic [15:0] wdata;
  } reg_req_type;

  // error and completion events from the command interpreter
  typedef struct packed {
    logic cmd_err;
    logic exec_err;
    logic dev_err;
    logic query_err;
    logic op_done;
  } std_events_type;

endpackage : status_reporting_pkg

/* File: hdl/event_group.sv */
// one condition/event/enable register group with its summary
`timescale 1ns/10ps
module event_group #(
  parameter int                 WIDTH      = 16,
  parameter logic [WIDTH-1:0]   IMPL_MASK  = '1,
  parameter logic [WIDTH-1:0]   EVENT_INIT = '0,
  parameter logic [WIDTH-1:0]   ENABLE_INIT = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic             event_clear_i,
  input  wire logic             enable_clear_i,
  input  wire logic             enable_write_i,
  input  wire logic [WIDTH-1:0] enable_data_i,
  output logic      [WIDTH-1:0] event_o,
  output logic      [WIDTH-1:0] enable_o,
  output logic                  summary_o
);

  logic [WIDTH-1:0] event_reg;
  logic [WIDTH-1:0] enable_reg;

  // set beats clear so an event arriving during a read is kept
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      event_reg <= EVENT_INIT;
    end else if (ce_i) begin
      event_reg <= ((event_clear_i ? '0 : event_reg) | set_i) & IMPL_MASK;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enable_reg <= ENABLE_INIT;
    end else if (ce_i) begin
      if (enable_clear_i) begin
        enable_reg <= '0;
      end else if (enable_write_i) begin
        enable_reg <= enable_data_i;
      end
    end
  end

  assign event_o   = event_reg;
  assign enable_o  = enable_reg;
  // combinational so the summary follows either register at once
  assign summary_o = |(event_reg & enable_reg);

endmodule : event_group

/* File: hdl/scpi_status_reporting.sv */
// status model: operation group, standard event group, status byte and service request
`timescale 1ns/10ps

// What this block does
// - operation condition follows live state, never latched
// - rising condition bits latch into event bits until cleared
// - enable masks are writable, readable and gate summary bits
// - operation register is 16 bits; only bits 0, 1 and 4 exist
// - reading operation event returns its value then clears it
// - status byte bit 7 set when enabled operation event is set
// - preset clears operation enable only, nothing else
// - clear-status clears events, status byte bits 5 and 7 and error queue, keeps masks; bit 4 still follows the output buffer
// - masked standard events drive status byte bit 5
// - power-on bit set at reset until read; bits 1 and 6 zero
// - bits 2 to 5 flag command, execution, device and query errors
// - bit 7 set once all commands through operation-complete finish
// - standard event enable is writable, readable and gates bit 5
// - status byte bit 4 shows output buffer holds data
// - clearing an event also clears its status byte summary
// - status byte read returns weighted sum of all its bits
// - service request enable selects bits summarized into bit 6
// - service request line asserts when enabled status events occur
// - scan-started condition bit is only momentary
// - operation-complete bit set when that command finishes executing
module scpi_status_reporting #(
  parameter int OPER_WIDTH = 16
) (
  input  wire logic                                 clk_i,
  input  wire logic                                 rst_n_i,
  input  wire logic                                 ce_i,
  input  wire logic                                 trig_wait_i,
  input  wire logic                                 arm_wait_i,
  input  wire logic                                 scan_start_i,
  input  wire status_reporting_pkg::std_events_type std_events_i,
  input  wire logic                                 out_buf_avail_i,
  input  wire status_reporting_pkg::reg_req_type    req_i,
  input  wire logic                                 preset_i,
  input  wire logic                                 clear_status_i,
  output logic                                      rd_valid_o,
  output logic      [15:0]                          rd_data_o,
  output logic                                      err_queue_clear_o,
  output logic                                      srq_o,
  output logic      [7:0]                           status_byte_o
);

  logic [OPER_WIDTH-1:0] oper_cond;
  logic [OPER_WIDTH-1:0] oper_cond_prev_reg;
  logic [OPER_WIDTH-1:0] oper_rise;
  logic [OPER_WIDTH-1:0] oper_event;
  logic [OPER_WIDTH-1:0] oper_enable;
  logic                  oper_summary;
  logic [7:0]            std_set;
  logic [7:0]            std_event;
  logic [7:0]            std_enable;
  logic                  std_summary;
  logic [7:0]            stb_raw;
  logic [7:0]            srq_enable_reg;
  logic                  rqs;
  logic                  rd_valid_reg;
  logic [15:0]           rd_data_reg;
  logic                  err_clear_reg;
  logic                  rd_oper_event;
  logic                  rd_std_event;

  function automatic logic is_op(input status_reporting_pkg::reg_req_type r,
                                 input status_reporting_pkg::reg_sel_type s,
                                 input logic wr);
    is_op = r.valid && (r.write == wr) && (r.sel == s);
  endfunction : is_op

  // live condition, no storage; scan start is a one-cycle pulse from the sequencer
  always_comb begin
    oper_cond = '0;
    oper_cond[status_reporting_pkg::OPER_TRIG_WAIT_BIT] = trig_wait_i;
    oper_cond[status_reporting_pkg::OPER_ARM_WAIT_BIT]  = arm_wait_i;
    oper_cond[status_reporting_pkg::OPER_SCAN_BIT]      = scan_start_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oper_cond_prev_reg <= '0;
    end else if (ce_i) begin
      oper_cond_prev_reg <= oper_cond;
    end
  end

  assign oper_rise     = oper_cond & ~oper_cond_prev_reg;
  assign rd_oper_event = is_op(req_i, status_reporting_pkg::SEL_OPER_EVENT, 1'b0);
  assign rd_std_event  = is_op(req_i, status_reporting_pkg::SEL_STD_EVENT, 1'b0);

  // unimplemented enable positions are stored but gate nothing
  event_group #(
    .WIDTH       (OPER_WIDTH),
    .IMPL_MASK   (OPER_WIDTH'(status_reporting_pkg::OPER_IMPL_MASK)),
    .EVENT_INIT  (OPER_WIDTH'(status_reporting_pkg::OPER_EVENT_RESET)),
    .ENABLE_INIT (OPER_WIDTH'(status_reporting_pkg::OPER_ENABLE_RESET))
  ) oper_group (
    .clk_i          (clk_i),
    .rst_n_i        (rst_n_i),
    .ce_i           (ce_i),
    .set_i          (oper_rise),
    .event_clear_i  (rd_oper_event || clear_status_i),
    .enable_clear_i (preset_i),
    .enable_write_i (is_op(req_i, status_reporting_pkg::SEL_OPER_ENABLE, 1'b1)),
    .enable_data_i  (req_i.wdata[OPER_WIDTH-1:0]),
    .event_o        (oper_event),
    .enable_o       (oper_enable),
    .summary_o      (oper_summary)
  );

  always_comb begin
    std_set = '0;
    std_set[status_reporting_pkg::STD_CMD_ERR_BIT]   = std_events_i.cmd_err;
    std_set[status_reporting_pkg::STD_EXEC_ERR_BIT]  = std_events_i.exec_err;
    std_set[status_reporting_pkg::STD_DEV_ERR_BIT]   = std_events_i.dev_err;
    std_set[status_reporting_pkg::STD_QUERY_ERR_BIT] = std_events_i.query_err;
    std_set[status_reporting_pkg::STD_OP_DONE_BIT]   = std_events_i.op_done;
  end

  // power-on bit comes from the reset value; bits 1 and 6 masked off
  event_group #(
    .WIDTH       (8),
    .IMPL_MASK   (status_reporting_pkg::STD_IMPL_MASK),
    .EVENT_INIT  (status_reporting_pkg::STD_EVENT_RESET),
    .ENABLE_INIT (status_reporting_pkg::STD_ENABLE_RESET)
  ) std_group (
    .clk_i          (clk_i),
    .rst_n_i        (rst_n_i),
    .ce_i           (ce_i),
    .set_i          (std_set),
    .event_clear_i  (rd_std_event || clear_status_i),
    .enable_clear_i (1'b0),
    .enable_write_i (is_op(req_i, status_reporting_pkg::SEL_STD_ENABLE, 1'b1)),
    .enable_data_i  (req_i.wdata[7:0]),
    .event_o        (std_event),
    .enable_o       (std_enable),
    .summary_o      (std_summary)
  );

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      srq_enable_reg <= status_reporting_pkg::SRQ_ENABLE_RESET;
    end else if (ce_i && is_op(req_i, status_reporting_pkg::SEL_SRQ_ENABLE, 1'b1)) begin
      srq_enable_reg <= req_i.wdata[7:0];
    end
  end

  // status byte is pure summary, so clearing any source clears it too
  always_comb begin
    stb_raw = '0;
    stb_raw[status_reporting_pkg::STB_MAV_BIT] = out_buf_avail_i;
    stb_raw[status_reporting_pkg::STB_ESB_BIT] = std_summary;
    stb_raw[status_reporting_pkg::STB_OPR_BIT] = oper_summary;
  end

  // bit 6 excluded from its own mask to avoid a loop
  assign rqs = |(stb_raw & srq_enable_reg & ~(8'h01 << status_reporting_pkg::STB_RQS_BIT));

  always_comb begin
    status_byte_o = stb_raw;
    status_byte_o[status_reporting_pkg::STB_RQS_BIT] = rqs;
  end

  // line follows the request summary, released as soon as nothing enabled remains
  assign srq_o = rqs;

  // read answer one cycle after the request
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= 16'h0000;
    end else if (ce_i) begin
      rd_valid_reg <= req_i.valid && !req_i.write;
      if (req_i.valid && !req_i.write) begin
        unique case (req_i.sel)
          status_reporting_pkg::SEL_OPER_COND:   rd_data_reg <= 16'(oper_cond);
          status_reporting_pkg::SEL_OPER_EVENT:  rd_data_reg <= 16'(oper_event);
          status_reporting_pkg::SEL_OPER_ENABLE: rd_data_reg <= 16'(oper_enable);
          status_reporting_pkg::SEL_STD_EVENT:   rd_data_reg <= {8'h00, std_event};
          status_reporting_pkg::SEL_STD_ENABLE:  rd_data_reg <= {8'h00, std_enable};
          status_reporting_pkg::SEL_STATUS_BYTE: rd_data_reg <= {8'h00, status_byte_o};
          status_reporting_pkg::SEL_SRQ_ENABLE:  rd_data_reg <= {8'h00, srq_enable_reg};
          status_reporting_pkg::SEL_NONE:        rd_data_reg <= 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      err_clear_reg <= 1'b0;
    end else if (ce_i) begin
      err_clear_reg <= clear_status_i;
    end
  end

  assign rd_valid_o        = rd_valid_reg;
  assign rd_data_o         = rd_data_reg;
  assign err_queue_clear_o = err_clear_reg;

endmodule : scpi_status_reporting

/* File: testbench/scpi_status_reporting_props.sv */
// concurrent checks on the status reporting ports
`timescale 1ns/10ps
module scpi_status_reporting_checker (
  input wire logic                                 clk_i,
  input wire logic                                 rst_n_i,
  input wire logic                                 ce_i,
  input wire logic                                 trig_wait_i,
  input wire logic                                 arm_wait_i,
  input wire logic                                 scan_start_i,
  input wire status_reporting_pkg::std_events_type std_events_i,
  input wire logic                                 out_buf_avail_i,
  input wire status_reporting_pkg::reg_req_type    req_i,
  input wire logic                                 preset_i,
  input wire logic                                 clear_status_i,
  input wire logic                                 rd_valid_o,
  input wire logic [15:0]                          rd_data_o,
  input wire logic                                 err_queue_clear_o,
  input wire logic                                 srq_o,
  input wire logic [7:0]                           status_byte_o
);
  logic       wr;
  logic       rd;
  logic       quiet;
  logic [7:0] sre_reg;
  logic [7:0] ese_reg;
  logic       oen_reg;
  assign wr    = ce_i & req_i.valid & req_i.write;
  assign rd    = ce_i & req_i.valid & !req_i.write;
  // nothing could set an event at this edge
  assign quiet = !scan_start_i & !trig_wait_i & !arm_wait_i & (std_events_i == '0);
  // mask shadows, so no internal probes are needed
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sre_reg <= '0;
      ese_reg <= '0;
      oen_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr && req_i.sel == status_reporting_pkg::SEL_SRQ_ENABLE) sre_reg <= req_i.wdata[7:0];
      if (wr && req_i.sel == status_reporting_pkg::SEL_STD_ENABLE) ese_reg <= req_i.wdata[7:0];
      if (preset_i) oen_reg <= 1'b0;
      else if (wr && req_i.sel == status_reporting_pkg::SEL_OPER_ENABLE) oen_reg <= req_i.wdata[4];
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_event_read;
    rd && req_i.sel == status_reporting_pkg::SEL_OPER_EVENT && quiet;
  endsequence
  sequence s_clear_quiet;
    ce_i && clear_status_i && quiet;
  endsequence
  a_read_answer: assert property (rd |=> rd_valid_o) else $error("read not answered");
  a_data_holds: assert property (!rd |=> $stable(rd_data_o)) else $error("read data moved");
  a_event_read_clr: assert property (s_event_read |=> !status_byte_o[7]) else $error("opr kept");
  a_scan_summary: assert property (ce_i && scan_start_i && oen_reg && !preset_i && !wr |=> status_byte_o[7])
    else $error("opr not set");
  a_done_summary: assert property (ce_i && std_events_i.op_done && ese_reg[7] && !wr |=> status_byte_o[5])
    else $error("esb not set");
  a_clear_status: assert property (s_clear_quiet |=> !status_byte_o[7] && !status_byte_o[5] && err_queue_clear_o)
    else $error("clear status failed");
  a_mav_level: assert property (status_byte_o[4] == out_buf_avail_i) else $error("mav wrong");
  a_rqs_sum: assert property (status_byte_o[6] == |(status_byte_o & sre_reg & 8'hbf)) else $error("rqs wrong");
  a_srq_follow: assert property (srq_o == status_byte_o[6]) else $error("srq wrong");
endmodule : scpi_status_reporting_checker

bind scpi_status_reporting scpi_status_reporting_checker u_props (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
  .trig_wait_i(trig_wait_i), .arm_wait_i(arm_wait_i), .scan_start_i(scan_start_i), .std_events_i(std_events_i),
  .out_buf_avail_i(out_buf_avail_i), .req_i(req_i), .preset_i(preset_i), .clear_status_i(clear_status_i),
  .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .err_queue_clear_o(err_queue_clear_o), .srq_o(srq_o),
  .status_byte_o(status_byte_o));

/* File: testbench/host_ctrl_model.sv */
// host bus controller model issuing register commands
`timescale 1ns/10ps
module host_ctrl_model (
  input  wire logic                         clk_i,
  input  wire logic                         rd_valid_i,
  input  wire logic [15:0]                  rd_data_i,
  output status_reporting_pkg::reg_req_type req_o
);
  initial req_o = '0;
  task automatic wr(input status_reporting_pkg::reg_sel_type s, input logic [15:0] d);
    @(posedge clk_i);
    // only the implemented weights go to the operation mask
    req_o <= '{1'b1, 1'b1, s, (s == status_reporting_pkg::SEL_OPER_ENABLE) ? (d & 16'h0013) : d};
    @(posedge clk_i);
    req_o <= '0;
    // let the write settle before anyone looks at the outputs
    #1;
  endtask : wr
  task automatic rd(input status_reporting_pkg::reg_sel_type s, output logic [15:0] d, output logic ok);
    ok = 1'b0;
    d  = '0;
    @(posedge clk_i);
    req_o <= '{1'b1, 1'b0, s, 16'h0000};
    @(posedge clk_i);
    req_o <= '0;
    #1;
    // bounded wait, a lost answer must not hang the run
    for (int i = 0; i < 8 && !ok; i++) begin
      if (rd_valid_i === 1'b1) begin
        d  = rd_data_i;
        ok = 1'b1;
      end else begin
        @(posedge clk_i);
        #1;
      end
    end
  endtask : rd
endmodule : host_ctrl_model

/* File: testbench/scpi_status_reporting_tb.sv */
// self-checking bench for the status reporting block
`timescale 1ns/10ps
module scpi_status_reporting_tb;
  logic                                 clk_i = 1'b0;
  logic                                 rst_n_i = 1'b0;
  logic                                 ce_i = 1'b1;
  logic                                 trig_wait_i = 1'b0;
  logic                                 arm_wait_i = 1'b0;
  logic                                 scan_start_i = 1'b0;
  status_reporting_pkg::std_events_type std_events_i = '0;
  logic                                 out_buf_avail_i = 1'b0;
  status_reporting_pkg::reg_req_type    req_i;
  logic                                 preset_i = 1'b0;
  logic                                 clear_status_i = 1'b0;
  logic                                 rd_valid_o;
  logic [15:0]                          rd_data_o;
  logic                                 err_queue_clear_o;
  logic                                 srq_o;
  logic [7:0]                           status_byte_o;
  int                                   n_mismatch = 0;
  int                                   comparisons = 0;
  initial forever #25 clk_i = !clk_i;
  scpi_status_reporting u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .trig_wait_i(trig_wait_i),
    .arm_wait_i(arm_wait_i), .scan_start_i(scan_start_i), .std_events_i(std_events_i),
    .out_buf_avail_i(out_buf_avail_i), .req_i(req_i), .preset_i(preset_i), .clear_status_i(clear_status_i),
    .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .err_queue_clear_o(err_queue_clear_o), .srq_o(srq_o),
    .status_byte_o(status_byte_o));
  host_ctrl_model u_host (.clk_i(clk_i), .rd_valid_i(rd_valid_o), .rd_data_i(rd_data_o), .req_o(req_i));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("comparisons=%0d mismatches=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic rd_chk(input status_reporting_pkg::reg_sel_type s, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    u_host.rd(s, d, ok);
    if (!ok) begin
      n_mismatch++;
      report_and_stop();
    end else begin
      chk(d, exp);
    end
  endtask : rd_chk
  task automatic sb_chk(input logic [7:0] exp);
    chk({8'h00, status_byte_o}, {8'h00, exp});
  endtask : sb_chk
  task automatic pulse_std(input status_reporting_pkg::std_events_type v);
    @(posedge clk_i);
    std_events_i <= v;
    @(posedge clk_i);
    std_events_i <= '0;
    #1;
  endtask : pulse_std
  initial begin
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk(status_reporting_pkg::SEL_STD_EVENT, 16'h0001);
    rd_chk(status_reporting_pkg::SEL_STD_EVENT, 16'h0000);
    sb_chk(8'h00);
    $display("test reset done");
    u_host.wr(status_reporting_pkg::SEL_OPER_ENABLE, 16'h0013);
    u_host.wr(status_reporting_pkg::SEL_STD_ENABLE, 16'h00bc);
    u_host.wr(status_reporting_pkg::SEL_SRQ_ENABLE, 16'h00a0);
    rd_chk(status_reporting_pkg::SEL_OPER_ENABLE, 16'h0013);
    rd_chk(status_reporting_pkg::SEL_STD_ENABLE, 16'h00bc);
    rd_chk(status_reporting_pkg::SEL_SRQ_ENABLE, 16'h00a0);
    @(posedge clk_i);
    preset_i <= 1'b1;
    @(posedge clk_i);
    preset_i <= 1'b0;
    rd_chk(status_reporting_pkg::SEL_OPER_ENABLE, 16'h0000);
    rd_chk(status_reporting_pkg::SEL_STD_ENABLE, 16'h00bc);
    u_host.wr(status_reporting_pkg::SEL_OPER_ENABLE, 16'h0013);
    $display("test masks done");
    @(posedge clk_i);
    scan_start_i <= 1'b1;
    @(posedge clk_i);
    scan_start_i <= 1'b0;
    #1;
    sb_chk(8'hc0);
    chk({15'h0000, srq_o}, 16'h0001);
    rd_chk(status_reporting_pkg::SEL_OPER_COND, 16'h0000);
    trig_wait_i <= 1'b1;
    arm_wait_i  <= 1'b1;
    rd_chk(status_reporting_pkg::SEL_OPER_COND, 16'h0003);
    trig_wait_i <= 1'b0;
    arm_wait_i  <= 1'b0;
    rd_chk(status_reporting_pkg::SEL_OPER_COND, 16'h0000);
    rd_chk(status_reporting_pkg::SEL_OPER_EVENT, 16'h0013);
    sb_chk(8'h00);
    chk({15'h0000, srq_o}, 16'h0000);
    rd_chk(status_reporting_pkg::SEL_OPER_EVENT, 16'h0000);
    $display("test operation done");
    for (int i = 0; i < 5; i++) pulse_std(5'h10 >> i);
    sb_chk(8'h60);
    rd_chk(status_reporting_pkg::SEL_STATUS_BYTE, 16'h0060);
    rd_chk(status_reporting_pkg::SEL_STD_EVENT, 16'h00bc);
    sb_chk(8'h00);
    pulse_std(5'h01);
    sb_chk(8'h60);
    @(posedge clk_i);
    clear_status_i <= 1'b1;
    @(posedge clk_i);
    clear_status_i <= 1'b0;
    #1;
    chk({15'h0000, err_queue_clear_o}, 16'h0001);
    sb_chk(8'h00);
    rd_chk(status_reporting_pkg::SEL_STD_EVENT, 16'h0000);
    rd_chk(status_reporting_pkg::SEL_SRQ_ENABLE, 16'h00a0);
    $display("test standard events done");
    out_buf_avail_i <= 1'b1;
    u_host.wr(status_reporting_pkg::SEL_SRQ_ENABLE, 16'h0010);
    sb_chk(8'h50);
    rd_chk(status_reporting_pkg::SEL_STATUS_BYTE, 16'h0050);
    rd_chk(status_reporting_pkg::SEL_NONE, 16'h0000);
    $display("test message available done");
    // a scan pulse while frozen must leave no trace
    @(posedge clk_i);
    ce_i         <= 1'b0;
    scan_start_i <= 1'b1;
    @(posedge clk_i);
    scan_start_i <= 1'b0;
    @(posedge clk_i);
    ce_i <= 1'b1;
    rd_chk(status_reporting_pkg::SEL_OPER_EVENT, 16'h0000);
    sb_chk(8'h50);
    $display("test clock enable done");
    report_and_stop();
  end
endmodule : scpi_status_reporting_tb
